// >>> seg_decode_pkg.sv
// shared constants, types and carriers for the virtual segment decoder
package seg_decode_pkg;

   // register byte offsets on the control bus
   localparam logic [31:0] ADDR_STATUS = 32'h0000_0000;
   localparam logic [31:0] ADDR_SPACE  = 32'h0000_0004;
   localparam logic [31:0] ADDR_CONFIG = 32'h0000_0008;
   localparam logic [31:0] ADDR_RESULT = 32'h0000_000C;
   localparam logic [31:0] ADDR_ERR_LO = 32'h0000_0010;
   localparam logic [31:0] ADDR_ERR_HI = 32'h0000_0014;

   // status register field positions and register reset values
   localparam int          ST_PRIV_LSB = 0;
   localparam int          ST_EXL_BIT  = 2;
   localparam int          ST_ERL_BIT  = 3;
   localparam int          ST_SX_BIT   = 4;
   localparam int          ST_KX_BIT   = 5;
   localparam logic [5:0]  STATUS_RST  = 6'h00;
   localparam logic [7:0]  SPACE_RST   = 8'h00;
   localparam logic [2:0]  CONFIG_RST  = 3'h2;

   // privilege encodings and cacheability codes
   localparam logic [1:0]  PRIV_KERN   = 2'h0;
   localparam logic [1:0]  PRIV_SUP    = 2'h1;
   localparam logic [2:0]  UNCACHED    = 3'h2;

   // bus responses
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // top of the mapped kernel window in the 11 region
   localparam logic [63:0] KMAP64_TOP  = 64'hC000_00FF_7FFF_FFFF;

   typedef enum logic [4:0] {
      SEG_NONE        = 5'h00,
      SEG_SUP_USER32  = 5'h01,
      SEG_SUP_OWN32   = 5'h02,
      SEG_SUP_USER64  = 5'h03,
      SEG_SUP_OWN64   = 5'h04,
      SEG_SUP_COMPAT  = 5'h05,
      SEG_K_USER32    = 5'h06,
      SEG_K_DC32      = 5'h07,
      SEG_K_DU32      = 5'h08,
      SEG_K_SUP32     = 5'h09,
      SEG_K_MAP32     = 5'h0A,
      SEG_K_USER64    = 5'h0B,
      SEG_K_SUP64     = 5'h0C,
      SEG_K_PHYS64    = 5'h0D,
      SEG_K_MAP64     = 5'h0E,
      SEG_K_CDC       = 5'h0F,
      SEG_K_CDU       = 5'h10,
      SEG_K_CSUP      = 5'h11,
      SEG_K_CMAP      = 5'h12,
      SEG_K_ERL_USER  = 5'h13
   } seg_type;

   typedef enum logic [1:0] {
      CSRC_UNCACHED   = 2'h0,
      CSRC_TLB        = 2'h1,
      CSRC_CONFIG     = 2'h2,
      CSRC_ADDR       = 2'h3
   } cache_src_type;

   typedef struct packed {
      logic [63:0]    base;
      logic [15:0]    offset;
   } acc_req_type;

   typedef struct packed {
      seg_type        seg;
      logic           mapped;
      logic [63:0]    tlb_vaddr;
      logic [7:0]     space_id;
      logic [31:0]    paddr;
      cache_src_type  cache_src;
      logic [2:0]     cache_attr;
      logic           addr_err;
      logic           overflow;
      logic           kern_mode;
   } dec_res_type;

endpackage

// >>> virtual_segment_decoder.sv
// segment decoder with mode state and an AXI4-Lite register slave
//
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ns

module virtual_segment_decoder
(
   input  wire logic                          sys_clk,
   input  wire logic                          sys_rst,
   input  wire logic [31:0]                   s_axi_awaddr,
   input  wire logic                          s_axi_awvalid,
   output      logic                          s_axi_awready,
   input  wire logic [31:0]                   s_axi_wdata,
   input  wire logic [3:0]                    s_axi_wstrb,
   input  wire logic                          s_axi_wvalid,
   output      logic                          s_axi_wready,
   output      logic [1:0]                    s_axi_bresp,
   output      logic                          s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   input  wire logic [31:0]                   s_axi_araddr,
   input  wire logic                          s_axi_arvalid,
   output      logic                          s_axi_arready,
   output      logic [31:0]                   s_axi_rdata,
   output      logic [1:0]                    s_axi_rresp,
   output      logic                          s_axi_rvalid,
   input  wire logic                          s_axi_rready,
   input  wire logic                          acc_valid,
   input  wire seg_decode_pkg::acc_req_type   acc_req,
   input  wire logic                          exc_event,
   input  wire logic                          exception_return_op,
   output      logic                          res_valid,
   output      seg_decode_pkg::dec_res_type   res,
   output      logic                          kern_mode
);
   import seg_decode_pkg::*;

   logic [31:0]  awaddr_reg;
   logic         aw_held_reg;
   logic [31:0]  wdata_reg;
   logic [3:0]   wstrb_reg;
   logic         w_held_reg;
   logic         bvalid_reg;
   logic [1:0]   bresp_reg;
   logic         rvalid_reg;
   logic [1:0]   rresp_reg;
   logic [31:0]  rdata_reg;
   logic         wr_fire;
   logic         wr_hit;
   logic [5:0]   status_reg;
   logic [7:0]   space_id_reg;
   logic [2:0]   cache_attr_reg;
   logic [63:0]  err_addr_reg;
   logic         res_valid_reg;
   dec_res_type  res_reg;
   logic [1:0]   privilege_field;
   logic         exception_level_flag;
   logic         error_level_flag;
   logic         sup_addr64_sel;
   logic         kern_addr64_sel;
   logic         sup_mode;
   logic         kern;
   logic         narrow;
   logic [63:0]  sum;
   logic [63:0]  va;
   logic         ovf;
   dec_res_type  d;
   logic [31:0]  status_wr;
   logic [31:0]  space_wr;
   logic [31:0]  config_wr;

   // byte-lane merge of a write into a register word
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
            r[8*i +: 8] = nw[8*i +: 8];
      end
      return r;
   endfunction

   // result for a segment translated through the TLB
   function automatic dec_res_type to_tlb(input dec_res_type r,
                                          input seg_type     s);
      dec_res_type o;
      o           = r;
      o.seg       = s;
      o.mapped    = 1'b1;
      o.cache_src = CSRC_TLB;
      return o;
   endfunction

   // result for an untranslated segment
   function automatic dec_res_type to_phys(input dec_res_type   r,
                                           input seg_type       s,
                                           input cache_src_type c,
                                           input logic [2:0]    a,
                                           input logic [31:0]   p);
      dec_res_type o;
      o            = r;
      o.seg        = s;
      o.mapped     = 1'b0;
      o.cache_src  = c;
      o.cache_attr = a;
      o.paddr      = p;
      return o;
   endfunction

   // held write word merged per byte lane into each register
   assign status_wr = merge({26'h0, status_reg}, wdata_reg, wstrb_reg);
   assign space_wr  = merge({24'h0, space_id_reg}, wdata_reg, wstrb_reg);
   assign config_wr = merge({29'h0, cache_attr_reg}, wdata_reg, wstrb_reg);

   // status fields
   assign privilege_field      = status_reg[ST_PRIV_LSB +: 2];
   assign exception_level_flag = status_reg[ST_EXL_BIT];
   assign error_level_flag     = status_reg[ST_ERL_BIT];
   assign sup_addr64_sel       = status_reg[ST_SX_BIT];
   assign kern_addr64_sel      = status_reg[ST_KX_BIT];

   assign sup_mode = (privilege_field == PRIV_SUP) &&
                     !exception_level_flag && !error_level_flag;
   assign kern     = (privilege_field == PRIV_KERN) ||
                     exception_level_flag || error_level_flag;
   assign narrow   = kern ? !kern_addr64_sel : !sup_addr64_sel;

   // effective address from base plus sign-extended offset
   assign sum = acc_req.base + {{48{acc_req.offset[15]}}, acc_req.offset};
   // sign-extend bit 31 in 32-bit addressing
   assign va  = narrow ? {{32{sum[31]}}, sum[31:0]} : sum;
   // overflow is only flagged; the address wraps at bit 31 and is still decoded
   assign ovf = narrow && (acc_req.offset[15] == acc_req.base[31]) &&
                (sum[31] != acc_req.base[31]);

   // segment decode for the current mode and width
   always_comb
   begin
      d           = '0;
      d.seg       = SEG_NONE;
      d.cache_src = CSRC_UNCACHED;
      d.kern_mode = kern;
      d.overflow  = ovf;
      // space id extends every mapped lookup
      d.space_id  = space_id_reg;
      d.tlb_vaddr = va;
      if (!kern && !sup_mode)
      begin
         // user segments are not decoded here
         d.addr_err = 1'b1;
      end
      else if (!kern)
      begin
         // every supervisor segment is TLB mapped
         if (narrow)
         begin
            if (!va[31])
               d = to_tlb(d, SEG_SUP_USER32);
            else if (va[31:29] == 3'b110)
               d = to_tlb(d, SEG_SUP_OWN32);
            else
               d.addr_err = 1'b1;
         end
         else
         begin
            case (va[63:62])
               2'b00:
               begin
                  // user window up to 1 Tbyte
                  if (va[61:40] == '0)
                     d = to_tlb(d, SEG_SUP_USER64);
                  else
                     d.addr_err = 1'b1;
               end
               2'b01:
               begin
                  // own window up to 1 Tbyte
                  if (va[61:40] == '0)
                     d = to_tlb(d, SEG_SUP_OWN64);
                  else
                     d.addr_err = 1'b1;
               end
               2'b11:
               begin
                  if (&va[61:31] && va[30:29] == 2'b10)
                     d = to_tlb(d, SEG_SUP_COMPAT);
                  else
                     d.addr_err = 1'b1;
               end
               default:
                  d.addr_err = 1'b1;
            endcase
         end
      end
      else if (narrow)
      begin
         case (va[31:29])
            3'b100:
               d = to_phys(d, SEG_K_DC32, CSRC_CONFIG, cache_attr_reg,
                           {3'h0, va[28:0]});
            3'b101:
               d = to_phys(d, SEG_K_DU32, CSRC_UNCACHED, UNCACHED,
                           {3'h0, va[28:0]});
            3'b110:
               d = to_tlb(d, SEG_K_SUP32);
            3'b111:
               d = to_tlb(d, SEG_K_MAP32);
            default:
            begin
               // error level turns the user window into plain memory
               if (error_level_flag)
                  d = to_phys(d, SEG_K_ERL_USER, CSRC_UNCACHED, UNCACHED,
                              {1'b0, va[30:0]});
               else
                  d = to_tlb(d, SEG_K_USER32);
            end
         endcase
      end
      else
      begin
         case (va[63:62])
            2'b00:
            begin
               // only the low 2 Gbytes under error level
               if (error_level_flag && va[61:31] == '0)
                  d = to_phys(d, SEG_K_ERL_USER, CSRC_UNCACHED, UNCACHED,
                              {1'b0, va[30:0]});
               else if (!error_level_flag && va[61:40] == '0)
                  d = to_tlb(d, SEG_K_USER64);
               else
                  d.addr_err = 1'b1;
            end
            2'b01:
            begin
               if (va[61:40] == '0)
                  d = to_tlb(d, SEG_K_SUP64);
               else
                  d.addr_err = 1'b1;
            end
            2'b10:
            begin
               // low 4 Gbytes of each window, attr from the address
               if (va[58:32] == '0)
                  d = to_phys(d, SEG_K_PHYS64, CSRC_ADDR, va[61:59],
                              va[31:0]);
               else
                  d.addr_err = 1'b1;
            end
            default:
            begin
               if (&va[61:31])
               begin
                  case (va[30:29])
                     2'b00:
                        d = to_phys(d, SEG_K_CDC, CSRC_CONFIG,
                                    cache_attr_reg, {3'h0, va[28:0]});
                     2'b01:
                        d = to_phys(d, SEG_K_CDU, CSRC_UNCACHED,
                                    UNCACHED, {3'h0, va[28:0]});
                     2'b10:
                        d = to_tlb(d, SEG_K_CSUP);
                     default:
                        d = to_tlb(d, SEG_K_CMAP);
                  endcase
               end
               else if (va <= KMAP64_TOP)
                  d = to_tlb(d, SEG_K_MAP64);
               else
                  d.addr_err = 1'b1;
            end
         endcase
      end
   end

   // physical address and cacheability leave together, one cycle later
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         res_valid_reg <= 1'b0;
         res_reg       <= '0;
      end
      else
      begin
         res_valid_reg <= acc_valid;
         if (acc_valid)
            res_reg <= d;
      end
   end

   // faulting address kept for software
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         err_addr_reg <= '0;
      else if (acc_valid && d.addr_err)
         err_addr_reg <= va;
   end

   // write address and data may arrive in either order
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         aw_held_reg <= 1'b0;
         w_held_reg  <= 1'b0;
         awaddr_reg  <= '0;
         wdata_reg   <= '0;
         wstrb_reg   <= '0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
         end
         else if (wr_fire)
            aw_held_reg <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
         end
         else if (wr_fire)
            w_held_reg <= 1'b0;
      end
   end

   // a channel stalls while its word waits or a response is pending
   assign s_axi_awready = !aw_held_reg && !bvalid_reg;
   assign s_axi_wready  = !w_held_reg && !bvalid_reg;
   assign wr_fire       = aw_held_reg && w_held_reg && !bvalid_reg;
   assign wr_hit        = (awaddr_reg == ADDR_STATUS) ||
                          (awaddr_reg == ADDR_SPACE) ||
                          (awaddr_reg == ADDR_CONFIG);

   // write response
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= RESP_OKAY;
      end
      else if (wr_fire)
      begin
         bvalid_reg <= 1'b1;
         bresp_reg  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
         bvalid_reg <= 1'b0;
   end

   // status: software write, then return, then exception wins last
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         status_reg <= STATUS_RST;
      else
      begin
         if (wr_fire && awaddr_reg == ADDR_STATUS)
            status_reg <= status_wr[5:0];
         if (exception_return_op)
         begin
            // error level is unwound before exception level
            if (error_level_flag)
               status_reg[ST_ERL_BIT] <= 1'b0;
            else
               status_reg[ST_EXL_BIT] <= 1'b0;
         end
         // a new exception in the same cycle as a return is not lost
         if (exc_event)
            status_reg[ST_EXL_BIT] <= 1'b1;
      end
   end

   // space id and unmapped cacheability
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         space_id_reg   <= SPACE_RST;
         cache_attr_reg <= CONFIG_RST;
      end
      else if (wr_fire && awaddr_reg == ADDR_SPACE)
         space_id_reg <= space_wr[7:0];
      else if (wr_fire && awaddr_reg == ADDR_CONFIG)
         cache_attr_reg <= config_wr[2:0];
   end

   // reads answer one cycle after the address is taken
   assign s_axi_arready = !rvalid_reg;

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         rvalid_reg <= 1'b0;
         rresp_reg  <= RESP_OKAY;
         rdata_reg  <= '0;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         rvalid_reg <= 1'b1;
         rresp_reg  <= RESP_OKAY;
         case (s_axi_araddr)
            ADDR_STATUS: rdata_reg <= {26'h0, status_reg};
            ADDR_SPACE:  rdata_reg <= {24'h0, space_id_reg};
            ADDR_CONFIG: rdata_reg <= {29'h0, cache_attr_reg};
            ADDR_RESULT: rdata_reg <= {17'h0, res_reg.seg, kern,
                                       res_reg.overflow, res_reg.addr_err,
                                       res_reg.mapped, res_reg.cache_src,
                                       res_reg.cache_attr, res_valid_reg};
            ADDR_ERR_LO: rdata_reg <= err_addr_reg[31:0];
            ADDR_ERR_HI: rdata_reg <= err_addr_reg[63:32];
            default:
            begin
               rdata_reg <= '0;
               rresp_reg <= RESP_SLVERR;
            end
         endcase
      end
      else if (s_axi_rready)
         rvalid_reg <= 1'b0;
   end

   // outputs
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp  = bresp_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rresp  = rresp_reg;
   assign s_axi_rdata  = rdata_reg;
   assign res_valid    = res_valid_reg;
   assign res          = res_reg;
   assign kern_mode    = kern;

endmodule

// >>> seg_decode_asserts.sv
// concurrent checks on the segment decoder ports
`timescale 1ns/1ns
module seg_decode_asserts
(
   input wire logic                        sys_clk,
   input wire logic                        sys_rst,
   input wire logic                        acc_valid,
   input wire logic                        exc_event,
   input wire logic                        res_valid,
   input wire seg_decode_pkg::dec_res_type res,
   input wire logic                        kern_mode
);
   import seg_decode_pkg::*;
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);
   // result timing: one pulse per request, record held between requests
   a_res_timing: assert property (acc_valid |=> res_valid)
      else $error("no result one cycle after a request");
   a_res_quiet: assert property (!acc_valid |=> !res_valid && $stable(res))
      else $error("result moved without a request");
   a_exc_kern: assert property (exc_event |=> kern_mode)
      else $error("exception did not force kernel mode");
   // segment contents, checked whenever a result is shown
   a_sup_mapped: assert property (res_valid && !res.kern_mode && !res.addr_err
      |-> res.mapped && res.cache_src == CSRC_TLB)
      else $error("supervisor access not mapped through the tlb");
   a_kern_seg: assert property (res_valid && res.kern_mode
      |-> !(res.seg inside {[SEG_SUP_USER32:SEG_SUP_COMPAT]}))
      else $error("kernel access decoded as supervisor segment");
   a_own_ext: assert property (res_valid && res.seg == SEG_SUP_OWN32
      |-> res.tlb_vaddr[63:29] == 35'h7FFFFFFFE)
      else $error("own window address not sign extended");
   a_dc_paddr: assert property (res_valid && res.seg == SEG_K_DC32
      |-> !res.mapped && res.cache_src == CSRC_CONFIG
          && res.paddr == {3'h0, res.tlb_vaddr[28:0]})
      else $error("direct cached space translated wrongly");
   a_du_uncached: assert property (res_valid && res.seg == SEG_K_DU32
      |-> res.cache_src == CSRC_UNCACHED && res.cache_attr == UNCACHED)
      else $error("direct uncached space not uncached");
   a_phys_attr: assert property (res_valid && res.seg == SEG_K_PHYS64
      && !res.addr_err |-> res.tlb_vaddr[58:32] == 27'h0
      && res.cache_attr == res.tlb_vaddr[61:59])
      else $error("physical window attribute or range wrong");
   a_mapped_pa: assert property (res_valid && res.mapped
      |-> res.paddr == 32'h0 && res.cache_src == CSRC_TLB)
      else $error("mapped access carries a physical address");
endmodule
bind virtual_segment_decoder seg_decode_asserts chk (.*);

// >>> agu_model.sv
// address generation stage model feeding the decoder request port
`timescale 1ns/1ns
module agu_model
(
   input  wire logic                        sys_clk,
   input  wire logic                        sys_rst,
   input  wire logic                        go,
   input  wire seg_decode_pkg::acc_req_type req,
   output      logic                        acc_valid,
   output      seg_decode_pkg::acc_req_type acc_req
);
   import seg_decode_pkg::*;
   // idle cycles show inverted data so a stale request never looks valid
   always_ff @(posedge sys_clk)
   begin
      acc_valid <= go && !sys_rst;
      acc_req   <= go ? req : ~req;
   end
endmodule

// >>> virtual_segment_decoder_tb.sv
// self-checking bench for the virtual segment decoder
`timescale 1ns/1ns
module virtual_segment_decoder_tb;
   import seg_decode_pkg::*;
   typedef struct packed {
      logic [5:0]    st;
      logic [63:0]   va;
      seg_type       seg;
      logic [31:0]   pa;
      cache_src_type cs;
   } row_type;
   // status, address, segment, physical, cache source; SEG_NONE is an error
   localparam row_type tbl [26] = '{
   '{6'h01, 64'h000000007FFFFFFF, SEG_SUP_USER32, 32'h0, CSRC_TLB},
   '{6'h01, 64'hFFFFFFFFDFFFFFFF, SEG_SUP_OWN32, 32'h0, CSRC_TLB},
   '{6'h01, 64'hFFFFFFFF80000000, SEG_NONE, 32'h0, CSRC_TLB},
   '{6'h11, 64'h000000FFFFFFFFFF, SEG_SUP_USER64, 32'h0, CSRC_TLB},
   '{6'h11, 64'h4000000000000000, SEG_SUP_OWN64, 32'h0, CSRC_TLB},
   '{6'h11, 64'hFFFFFFFFC0000000, SEG_SUP_COMPAT, 32'h0, CSRC_TLB},
   '{6'h11, 64'h0000010000000000, SEG_NONE, 32'h0, CSRC_TLB},
   '{6'h00, 64'h0000000080000000, SEG_K_DC32, 32'h0, CSRC_CONFIG},
   '{6'h00, 64'hFFFFFFFFA0000010, SEG_K_DU32, 32'h10, CSRC_UNCACHED},
   '{6'h00, 64'h000000007FFFFFFF, SEG_K_USER32, 32'h0, CSRC_TLB},
   '{6'h00, 64'hFFFFFFFFC0000000, SEG_K_SUP32, 32'h0, CSRC_TLB},
   '{6'h00, 64'hFFFFFFFFFFFFFFFF, SEG_K_MAP32, 32'h0, CSRC_TLB},
   '{6'h20, 64'h000000FFFFFFFFFF, SEG_K_USER64, 32'h0, CSRC_TLB},
   '{6'h20, 64'h400000FFFFFFFFFF, SEG_K_SUP64, 32'h0, CSRC_TLB},
   '{6'h20, 64'h90000000FFFFFFFF, SEG_K_PHYS64, 32'hFFFFFFFF, CSRC_ADDR},
   '{6'h20, 64'h8000000100000000, SEG_NONE, 32'h0, CSRC_TLB},
   '{6'h20, 64'hC000000000000000, SEG_K_MAP64, 32'h0, CSRC_TLB},
   '{6'h20, 64'hFFFFFFFF9FFFFFFF, SEG_K_CDC, 32'h1FFFFFFF, CSRC_CONFIG},
   '{6'h05, 64'hFFFFFFFF80000000, SEG_K_DC32, 32'h0, CSRC_CONFIG},
   '{6'h08, 64'h000000007FFFFFFF, SEG_K_ERL_USER, 32'h7FFFFFFF, CSRC_UNCACHED},
   '{6'h02, 64'h0000000000000000, SEG_NONE, 32'h0, CSRC_TLB},
   '{6'h20, 64'hFFFFFFFFBFFFFFFF, SEG_K_CDU, 32'h1FFFFFFF, CSRC_UNCACHED},
   '{6'h20, 64'hFFFFFFFFE0000000, SEG_K_CMAP, 32'h0, CSRC_TLB},
   '{6'h28, 64'h000000007FFFFFFF, SEG_K_ERL_USER, 32'h7FFFFFFF, CSRC_UNCACHED},
   '{6'h28, 64'h0000000080000000, SEG_NONE, 32'h0, CSRC_TLB},
   '{6'h20, 64'hC000010000000000, SEG_NONE, 32'h0, CSRC_TLB}};
   logic        sys_clk = 1'h0;
   logic        sys_rst = 1'h1;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
   logic [31:0] s_axi_araddr = 32'h0, s_axi_rdata, d;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, go = 1'h0;
   logic        exc_event = 1'h0, exception_return_op = 1'h0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, acc_valid, res_valid, kern_mode, aw_t, w_t, k;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic [63:0] x;
   acc_req_type acc_req, req = '0;
   dec_res_type res;
   int          n_fail = 0, checks = 0;

   virtual_segment_decoder dut (.*);
   agu_model agu (.sys_clk(sys_clk), .sys_rst(sys_rst), .go(go), .req(req),
                  .acc_valid(acc_valid), .acc_req(acc_req));

   // clock and a watchdog far beyond the few hundred cycles needed
   always #50 sys_clk = ~sys_clk;
   initial
   begin
      repeat (5000) @(posedge sys_clk);
      n_fail++;
      report_and_stop();
   end

   task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop();
      if (n_fail == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // each channel drops valid only at its own handshake edge
   task automatic wr(input logic [31:0] a, input logic [31:0] v);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      @(negedge sys_clk);
      while (!s_axi_bvalid)
      begin
         {aw_t, w_t} = {s_axi_awready, s_axi_wready};
         @(posedge sys_clk);
         if (aw_t) s_axi_awvalid <= 1'h0;
         if (w_t) s_axi_wvalid <= 1'h0;
         @(negedge sys_clk);
      end
      r = s_axi_bresp;
      // bready stays high so the response is taken and bvalid clears at this next edge
      @(posedge sys_clk);
   endtask

   task automatic rd(input logic [31:0] a);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      @(negedge sys_clk);
      while (!s_axi_rvalid)
      begin
         aw_t = s_axi_arready;
         @(posedge sys_clk);
         if (aw_t) s_axi_arvalid <= 1'h0;
         @(negedge sys_clk);
      end
      {d, r} = {s_axi_rdata, s_axi_rresp};
      @(posedge sys_clk);
   endtask

   // pipeline stage adds one cycle, the decoder answers one cycle later
   task automatic acc(input logic [63:0] b, input logic [15:0] o);
      req <= '{base: b, offset: o};
      go <= 1'h1;
      @(posedge sys_clk);
      go <= 1'h0;
      @(posedge sys_clk);
      @(negedge sys_clk);
      cmp(res_valid, 1'h1);
      @(posedge sys_clk);
   endtask

   initial
   begin
      repeat (20) @(posedge sys_clk);
      sys_rst <= 1'h0;
      @(negedge sys_clk);
      cmp({res_valid, kern_mode}, 2'h1);
      cmp({s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid,
           s_axi_rvalid}, 5'h1C);
      @(posedge sys_clk);
      rd(ADDR_STATUS);
      cmp({r, d}, {RESP_OKAY, 26'h0, STATUS_RST});
      rd(ADDR_CONFIG);
      cmp(d, CONFIG_RST);
      rd(32'h0000_0040);
      cmp({r, d}, {RESP_SLVERR, 32'h0});
      wr(ADDR_RESULT, 32'hFFFF_FFFF);
      cmp(r, RESP_SLVERR);
      for (int i = 0; i < 26; i++)
      begin
         wr(ADDR_STATUS, {26'h0, tbl[i].st});
         acc(tbl[i].va, 16'h0);
         cmp(res.addr_err, tbl[i].seg == SEG_NONE);
         k = tbl[i].st[1:0] != PRIV_SUP || tbl[i].st[3:2] != 2'h0;
         x = (k ? tbl[i].st[5] : tbl[i].st[4]) ? tbl[i].va
             : {{32{tbl[i].va[31]}}, tbl[i].va[31:0]};
         if (tbl[i].seg != SEG_NONE)
         begin
            cmp(res.seg, tbl[i].seg);
            cmp(res.mapped, tbl[i].cs == CSRC_TLB);
            cmp(res.paddr, tbl[i].pa);
            cmp(res.cache_src, tbl[i].cs);
            cmp(res.tlb_vaddr, x);
            cmp(res.kern_mode, k);
         end
      end
      // last faulting address and the packed result word
      rd(ADDR_ERR_HI);
      cmp(d, 32'hC000_0100);
      rd(ADDR_RESULT);
      cmp({r, d}, {RESP_OKAY, 32'h0000_0280});
      // awkward cases: wrap of bit 31, space tag, config attribute
      wr(ADDR_STATUS, 32'h0);
      acc(64'h0000_0000_7FFF_FFF0, 16'h0020);
      cmp(res.overflow, 1'h1);
      wr(ADDR_SPACE, 32'hA5);
      wr(ADDR_CONFIG, 32'h3);
      // a write with no byte lanes enabled leaves the space id alone
      s_axi_wstrb <= 4'h0;
      wr(ADDR_SPACE, 32'h5A);
      s_axi_wstrb <= 4'hF;
      acc(64'hFFFF_FFFF_C000_0000, 16'h0);
      cmp(res.space_id, 8'hA5);
      acc(64'hFFFF_FFFF_8000_0000, 16'h0);
      cmp(res.cache_attr, 3'h3);
      // exception enters kernel, return restores supervisor
      wr(ADDR_STATUS, 32'h01);
      cmp(kern_mode, 1'h0);
      exc_event <= 1'h1;
      @(posedge sys_clk);
      exc_event <= 1'h0;
      @(posedge sys_clk);
      cmp(kern_mode, 1'h1);
      exception_return_op <= 1'h1;
      @(posedge sys_clk);
      exception_return_op <= 1'h0;
      @(posedge sys_clk);
      cmp(kern_mode, 1'h0);
      report_and_stop();
   end
endmodule
